// *** src/dma_rpt_defines.svh ***
/*
  pointer strides, field encodings and reset values for the repeat-transfer dma engine.
  assumes nothing; definitions only.
*/
`ifndef DMA_RPT_DEFINES_SVH
`define DMA_RPT_DEFINES_SVH
// unit size encodings
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2
// pointer strides per unit size
`define STRIDE_BYTE 32'h00000001
`define STRIDE_HALF 32'h00000002
`define STRIDE_WORD 32'h00000004
// reset values
`define COUNT_RESET 32'h00000000
`define PTR_RESET   32'h00000000
// working count value whose decrement triggers reload
`define COUNT_LAST  32'h00000001
`endif

// *** src/dma_rpt_pkg.sv ***
/*
  types shared by the dma engine and its bus port interface.
  assumes dma_rpt_defines.svh for the numeric encodings.
*/
package dma_rpt_pkg;
  // transfer engine states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_READ  = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_DONE  = 4'b1000
  } xfer_state_t;
  typedef logic [1:0] unit_size_t;
endpackage

// *** src/dma_bus_if.sv ***
/*
  carrier between the channel engine and the bus port: one stolen cycle per beat.
  assumes a single clock domain.
*/
`timescale 1ns/1ps
interface dma_bus_if;
  logic        req;    // engine wants one bus cycle
  logic        we;     // write when high
  logic [31:0] addr;   // byte address
  logic [31:0] wdata;  // write data
  logic [1:0]  size;   // unit size
  logic        done;   // cycle finished
  logic [31:0] rdata;  // read data on done
  modport engine (output req, we, addr, wdata, size, input done, rdata);
  modport port   (input req, we, addr, wdata, size, output done, rdata);
endinterface

// *** src/dma_bus_port.sv ***
/*
  bus port: turns each engine beat into one stolen memory cycle granted by the cpu arbiter.
  assumes the arbiter grants single cycles and memory answers with ack.
*/
`timescale 1ns/1ps
module dma_bus_port
  import dma_rpt_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // engine side
  dma_bus_if.port          eng,
  // memory bus side
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  output logic [1:0]       mem_size,
  input  wire logic        mem_grant,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata
);
  logic        busy_reg;   // a granted cycle is in flight
  logic [31:0] rdata_reg;  // captured read data
  wire         take = eng.req & ~busy_reg & mem_grant;
  // memory may answer in the grant cycle itself, so the beat ends on either case
  wire         done_now = (busy_reg | take) & mem_ack;

  // request only between grants: one cycle is stolen, then the bus returns to the cpu
  assign mem_req   = eng.req & ~busy_reg;
  assign mem_we    = eng.we;
  assign mem_addr  = eng.addr;
  assign mem_wdata = eng.wdata;
  assign mem_size  = eng.size;
  assign eng.done  = done_now;
  assign eng.rdata = done_now ? mem_rdata : rdata_reg;

  // track the single stolen cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_reg  <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      // stay busy only when the grant came without its answer
      if (take & ~mem_ack) busy_reg <= 1'b1;
      else if (mem_ack) busy_reg <= 1'b0;
      if (done_now) rdata_reg <= mem_rdata;
    end
  end
endmodule // dma_bus_port

// *** src/dma_repeat_engine.sv ***
/*
  four channel repeat-transfer dma engine with cycle-stealing bus access.
  assumes channel setup arrives on plain ports and the cpu arbiter grants single cycles.
*/
`timescale 1ns/1ps
`include "dma_rpt_defines.svh"
module dma_repeat_engine
  import dma_rpt_pkg::*;
#(
  parameter int NCH = 4
)(
  // clock and reset
  input  wire logic              SYS_CLK,
  input  wire logic              RST,
  // channel setup, per channel
  input  wire logic [NCH-1:0]    CH_ENABLE,
  input  wire logic [NCH-1:0]    CH_REPEAT,
  input  wire logic [NCH-1:0]    CH_SRC_INC,
  input  wire logic [NCH-1:0]    CH_DST_INC,
  input  wire logic [NCH-1:0]    CH_PIN_TRIG,
  input  wire logic [NCH*2-1:0]  CH_SIZE,
  // software write of working and reload values
  input  wire logic              CFG_WRITE,
  input  wire logic [1:0]        CFG_CHAN,
  input  wire logic [31:0]       CFG_COUNT,
  input  wire logic [31:0]       CFG_SRC,
  input  wire logic [31:0]       CFG_DST,
  // request sources
  input  wire logic [NCH-1:0]    EXT_REQ_N,
  input  wire logic [NCH-1:0]    SW_REQ,
  // status
  output logic [NCH*32-1:0]      WORK_COUNT,
  output logic [NCH*32-1:0]      SRC_PTR,
  output logic [NCH*32-1:0]      DST_PTR,
  output logic [NCH-1:0]         CH_STOPPED,
  output logic                   XFER_BUSY,
  // memory bus
  output logic                   MEM_REQ,
  output logic                   MEM_WE,
  output logic [31:0]            MEM_ADDR,
  output logic [31:0]            MEM_WDATA,
  output logic [1:0]             MEM_SIZE,
  input  wire logic              MEM_GRANT,
  input  wire logic              MEM_ACK,
  input  wire logic [31:0]       MEM_RDATA
);
  ////////////////////////////////////////////////////////////////////////////////
  // per-channel storage
  logic [31:0] working_transfer_count      [NCH];
  logic [31:0] transfer_count_reload       [NCH];
  logic [31:0] current_source_pointer      [NCH];
  logic [31:0] source_pointer_reload       [NCH];
  logic [31:0] current_destination_pointer [NCH];
  logic [31:0] destination_pointer_reload  [NCH];
  logic [NCH-1:0] pend_reg;     // latched requests awaiting service
  logic [NCH-1:0] pin_reg;      // previous pin level
  logic [NCH-1:0] stop_reg;     // one-shot channel finished
  xfer_state_t    state_reg;    // transfer sequencer
  logic [1:0]     chan_reg;     // channel in service
  logic [31:0]    data_reg;     // unit held between read and write

  dma_bus_if bus ();

  // stride from unit size; words use four for byte addressing
  function automatic logic [31:0] stride(input logic [1:0] sz);
    if (sz == `SIZE_HALF) return `STRIDE_HALF;
    else if (sz == `SIZE_WORD) return `STRIDE_WORD;
    else return `STRIDE_BYTE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // request decode
  wire [NCH-1:0] pin_fall = pin_reg & ~EXT_REQ_N & CH_PIN_TRIG;
  wire [NCH-1:0] new_req  = (pin_fall | (SW_REQ & ~CH_PIN_TRIG)) & CH_ENABLE;
  wire [NCH-1:0] live     = pend_reg & ~stop_reg;
  // fixed priority, channel 0 first
  wire [1:0] pick = live[0] ? 2'h0 : live[1] ? 2'h1 : live[2] ? 2'h2 : 2'h3;
  wire       start = (state_reg == ST_IDLE) & (|live);
  wire [1:0] sz    = CH_SIZE[chan_reg*2 +: 2];
  wire       last  = working_transfer_count[chan_reg] == `COUNT_LAST;
  wire       fin   = state_reg == ST_DONE;

  // one read beat then one write beat, each its own stolen cycle
  assign bus.req   = (state_reg == ST_READ) | (state_reg == ST_WRITE);
  assign bus.we    = state_reg == ST_WRITE;
  assign bus.addr  = bus.we ? current_destination_pointer[chan_reg]
                            : current_source_pointer[chan_reg];
  assign bus.wdata = data_reg;
  assign bus.size  = sz;

  dma_bus_port u_port (
    .clk       (SYS_CLK),
    .rst       (RST),
    .eng       (bus),
    .mem_req   (MEM_REQ),
    .mem_we    (MEM_WE),
    .mem_addr  (MEM_ADDR),
    .mem_wdata (MEM_WDATA),
    .mem_size  (MEM_SIZE),
    .mem_grant (MEM_GRANT),
    .mem_ack   (MEM_ACK),
    .mem_rdata (MEM_RDATA)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_reg <= ST_IDLE;
      chan_reg  <= 2'h0;
      data_reg  <= 32'h00000000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            chan_reg  <= pick;
            state_reg <= ST_READ;
          end
        end
        ST_READ: begin
          if (bus.done) begin
            data_reg  <= bus.rdata;
            state_reg <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (bus.done) state_reg <= ST_DONE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // request latch: a new request wins over the clear of the one just served
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pend_reg <= '0;
      pin_reg  <= '1;
    end else begin
      pin_reg  <= EXT_REQ_N;
      pend_reg <= (pend_reg & ~(start ? (NCH'(1) << pick) : '0)) | new_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // counts and pointers, updated once per completed unit
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      stop_reg <= '0;
      for (int i = 0; i < NCH; i++) begin
        working_transfer_count[i]      <= `COUNT_RESET;
        transfer_count_reload[i]       <= `COUNT_RESET;
        current_source_pointer[i]      <= `PTR_RESET;
        source_pointer_reload[i]       <= `PTR_RESET;
        current_destination_pointer[i] <= `PTR_RESET;
        destination_pointer_reload[i]  <= `PTR_RESET;
      end
    end else begin
      if (fin) begin
        if (last & CH_REPEAT[chan_reg]) begin
          // reload all three in the same step
          working_transfer_count[chan_reg]      <= transfer_count_reload[chan_reg];
          current_source_pointer[chan_reg]      <= source_pointer_reload[chan_reg];
          current_destination_pointer[chan_reg] <= destination_pointer_reload[chan_reg];
        end else begin
          working_transfer_count[chan_reg] <= working_transfer_count[chan_reg] - 32'h00000001;
          if (CH_SRC_INC[chan_reg])
            current_source_pointer[chan_reg] <= current_source_pointer[chan_reg] + stride(sz);
          // fixed destination holds its value
          if (CH_DST_INC[chan_reg])
            current_destination_pointer[chan_reg] <= current_destination_pointer[chan_reg] + stride(sz);
          if (last) stop_reg[chan_reg] <= 1'b1;  // single-shot end
        end
      end
      // software write loads working and reload copies, restarts a stopped channel; ignored when that channel finishes a unit in the same cycle
      if (CFG_WRITE & ~(fin & (chan_reg == CFG_CHAN))) begin
        working_transfer_count[CFG_CHAN]      <= CFG_COUNT;
        transfer_count_reload[CFG_CHAN]       <= CFG_COUNT;
        current_source_pointer[CFG_CHAN]      <= CFG_SRC;
        source_pointer_reload[CFG_CHAN]       <= CFG_SRC;
        current_destination_pointer[CFG_CHAN] <= CFG_DST;
        destination_pointer_reload[CFG_CHAN]  <= CFG_DST;
        stop_reg[CFG_CHAN]                    <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status out
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      WORK_COUNT[i*32 +: 32] = working_transfer_count[i];
      SRC_PTR[i*32 +: 32]    = current_source_pointer[i];
      DST_PTR[i*32 +: 32]    = current_destination_pointer[i];
    end
  end
  assign CH_STOPPED = stop_reg;
  assign XFER_BUSY  = state_reg != ST_IDLE;
endmodule // dma_repeat_engine

// *** tb/dma_repeat_engine_sva.sv ***
/* checker for the repeat dma engine, seen from channel 0 and the memory bus.
   assumes a bind from the bench top and a single clock. */
`timescale 1ns/1ps
`include "dma_rpt_defines.svh"
module dma_repeat_engine_sva #(
  parameter int NCH = 4
)(
  // clock, reset and setup
  input wire logic              SYS_CLK, RST, CFG_WRITE, XFER_BUSY,
  input wire logic [NCH-1:0]    CH_ENABLE, CH_REPEAT, CH_DST_INC, CH_PIN_TRIG, EXT_REQ_N,
  input wire logic [NCH*2-1:0]  CH_SIZE,
  // status and memory bus
  input wire logic [NCH*32-1:0] WORK_COUNT, SRC_PTR, DST_PTR,
  input wire logic              MEM_REQ, MEM_WE, MEM_GRANT, MEM_ACK,
  input wire logic [31:0]       MEM_ADDR,
  input wire logic [1:0]        MEM_SIZE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // address checks only hold when channel 0 is the sole bus user
  wire        only0 = (CH_ENABLE == {{(NCH-1){1'b0}}, 1'b1});
  wire [31:0] cnt0  = WORK_COUNT[31:0];
  wire [31:0] step0 = (CH_SIZE[1:0] == `SIZE_BYTE) ? `STRIDE_BYTE :
                      (CH_SIZE[1:0] == `SIZE_HALF) ? `STRIDE_HALF : `STRIDE_WORD;
  a_req_holds: assert property (MEM_REQ && !MEM_GRANT |=> MEM_REQ && $stable(MEM_ADDR))
    else $error("bus request dropped before grant");
  a_beat_release: assert property (MEM_ACK && MEM_WE |=> !MEM_REQ)
    else $error("bus kept after write beat");
  a_pin_start: assert property (only0 && CH_PIN_TRIG[0] && !XFER_BUSY && $fell(EXT_REQ_N[0])
    |-> ##[1:3] (MEM_REQ && !MEM_WE)) else $error("pin edge started no read");
  a_read_src: assert property (only0 && MEM_REQ && !MEM_WE |-> MEM_ADDR == SRC_PTR[31:0])
    else $error("read not at source pointer");
  a_write_dst: assert property (only0 && MEM_REQ && MEM_WE |-> MEM_ADDR == DST_PTR[31:0])
    else $error("write not at destination pointer");
  a_count_step: assert property ($changed(cnt0) && !$past(CFG_WRITE)
    |-> cnt0 == $past(cnt0) - 32'h1 || $past(cnt0) == `COUNT_LAST) else $error("count step wrong");
  a_repeat_reload: assert property ($past(CH_REPEAT[0]) && $past(cnt0) == `COUNT_LAST && $changed(cnt0)
    && !$past(CFG_WRITE) |-> cnt0 != `COUNT_RESET) else $error("repeat count reached zero");
  a_dst_fixed: assert property (!$past(CH_DST_INC[0]) && $changed(DST_PTR[31:0]) && !$past(CFG_WRITE)
    |-> $past(cnt0) == `COUNT_LAST) else $error("fixed destination moved");
  a_src_stride: assert property ($changed(SRC_PTR[31:0]) && !$past(CFG_WRITE) && $past(cnt0) != `COUNT_LAST
    |-> SRC_PTR[31:0] - $past(SRC_PTR[31:0]) == $past(step0)) else $error("source stride wrong");
  a_size_match: assert property (only0 && MEM_REQ |-> MEM_SIZE == CH_SIZE[1:0])
    else $error("bus size differs from channel size");
endmodule // dma_repeat_engine_sva

// *** tb/dma_mem_model.sv ***
/* memory and cpu arbiter model: grants single stolen cycles, answers reads, logs writes.
   assumes one clock; slow makes the cpu keep the bus two more cycles. */
`timescale 1ns/1ps
module dma_mem_model (
  input  wire logic        clk, rst, slow, req, we,
  input  wire logic [31:0] addr, wdata,
  output logic             grant, ack,
  output logic [31:0]      rdata, wr_addr, wr_data,
  output logic [7:0]       wr_cnt
);
  logic [1:0]  wait_reg;  // cycles the cpu has held the bus
  logic [31:0] junk_reg;  // read bus content outside an ack
  assign grant = req && (!slow || wait_reg == 2'h2);
  assign ack   = grant;
  // a toggling pattern outside ack, so stale data never looks valid
  assign rdata = ack ? (addr ^ 32'h5a5a5a5a) : junk_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_reg <= 2'h0;
      junk_reg <= 32'h0;
      wr_cnt   <= 8'h0;
      wr_addr  <= 32'h0;
      wr_data  <= 32'h0;
    end else begin
      wait_reg <= (req && !grant) ? wait_reg + 2'h1 : 2'h0;
      junk_reg <= ~junk_reg;
      if (ack && we) begin
        wr_cnt  <= wr_cnt + 8'h1;
        wr_addr <= addr;
        wr_data <= wdata;
      end
    end
  end
endmodule // dma_mem_model

// *** tb/testbench.sv ***
/* bench for the repeat dma engine: app-style repeat run on channel 0, sizes on channels 1 to 3.
   assumes the memory model answers every beat. */
`timescale 1ns/1ps
module testbench;
  logic         SYS_CLK = 1'b0, RST = 1'b1, CFG_WRITE = 1'b0, slow = 1'b0;
  logic [3:0]   CH_ENABLE = 4'h0, CH_REPEAT = 4'h0, CH_SRC_INC = 4'h0, CH_DST_INC = 4'h0;
  logic [3:0]   CH_PIN_TRIG = 4'h0, EXT_REQ_N = 4'hf, SW_REQ = 4'h0, CH_STOPPED;
  logic [7:0]   CH_SIZE = 8'h00, wr_cnt;
  logic [1:0]   CFG_CHAN = 2'h0, MEM_SIZE;
  logic [31:0]  CFG_COUNT = 32'h0, CFG_SRC = 32'h0, CFG_DST = 32'h0;
  logic [31:0]  MEM_ADDR, MEM_WDATA, MEM_RDATA, wr_addr, wr_data;
  logic [127:0] WORK_COUNT, SRC_PTR, DST_PTR;
  logic         XFER_BUSY, MEM_REQ, MEM_WE, MEM_GRANT, MEM_ACK;
  logic [31:0]  e_cnt[4], e_src[4], e_dst[4], r_cnt[4], r_src[4], r_dst[4];
  int           miscompares = 0, checks_done = 0;
  always #4 SYS_CLK = ~SYS_CLK;
  dma_repeat_engine u_dma_repeat_engine (.SYS_CLK, .RST, .CH_ENABLE, .CH_REPEAT, .CH_SRC_INC,
    .CH_DST_INC, .CH_PIN_TRIG, .CH_SIZE, .CFG_WRITE, .CFG_CHAN, .CFG_COUNT, .CFG_SRC, .CFG_DST,
    .EXT_REQ_N, .SW_REQ, .WORK_COUNT, .SRC_PTR, .DST_PTR, .CH_STOPPED, .XFER_BUSY, .MEM_REQ,
    .MEM_WE, .MEM_ADDR, .MEM_WDATA, .MEM_SIZE, .MEM_GRANT, .MEM_ACK, .MEM_RDATA);
  dma_mem_model u_dma_mem_model (.clk(SYS_CLK), .rst(RST), .slow, .req(MEM_REQ), .we(MEM_WE),
    .addr(MEM_ADDR), .wdata(MEM_WDATA), .grant(MEM_GRANT), .ack(MEM_ACK), .rdata(MEM_RDATA),
    .wr_addr, .wr_data, .wr_cnt);
  task automatic close_out;
    if (miscompares == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // software load of working and reload copies
  task automatic cfg(input int ch, input logic [31:0] cnt, input logic [31:0] src, input logic [31:0] dst);
    CFG_CHAN = 2'(ch);
    CFG_COUNT = cnt;
    CFG_SRC = src;
    CFG_DST = dst;
    CFG_WRITE = 1'b1;
    @(negedge SYS_CLK);
    CFG_WRITE = 1'b0;
    {e_cnt[ch], e_src[ch], e_dst[ch]} = {cnt, src, dst};
    {r_cnt[ch], r_src[ch], r_dst[ch]} = {cnt, src, dst};
  endtask
  // one request by pin edge or pulse, then bounded waits for the beat and idle
  task automatic fire(input int ch, input bit pin, input bit moves);
    logic [7:0] start;
    int n;
    start = wr_cnt;
    if (pin) EXT_REQ_N[ch] = 1'b0;
    else SW_REQ[ch] = 1'b1;
    @(negedge SYS_CLK);
    SW_REQ = 4'h0;
    for (n = 0; n < 40 && wr_cnt === start; n++) @(negedge SYS_CLK);
    chk("write beats", 32'(start) + 32'(moves), 32'(wr_cnt));
    if (moves && wr_cnt === start) close_out();
    for (n = 0; n < 40 && XFER_BUSY !== 1'b0; n++) @(negedge SYS_CLK);
    if (n == 40) begin
      miscompares++;
      close_out();
    end
    // pin back high for three edges, so the next call makes a fresh falling edge
    EXT_REQ_N = 4'hf;
    repeat (3) @(negedge SYS_CLK);
  endtask
  // one unit on a repeat channel, checked against the tracked pointers
  task automatic unit(input int ch, input bit pin);
    logic [31:0] st, m;
    st = 32'h1 << CH_SIZE[ch*2+:2];
    m = (st == 32'h4) ? 32'hffffffff : (32'h1 << (8 * st)) - 32'h1;
    fire(ch, pin, 1'b1);
    chk("write addr", e_dst[ch], wr_addr);
    chk("write data", (e_src[ch] ^ 32'h5a5a5a5a) & m, wr_data & m);
    if (e_cnt[ch] == 32'h1) {e_cnt[ch], e_src[ch], e_dst[ch]} = {r_cnt[ch], r_src[ch], r_dst[ch]};
    else begin
      e_cnt[ch] = e_cnt[ch] - 32'h1;
      e_src[ch] = e_src[ch] + (CH_SRC_INC[ch] ? st : 32'h0);
      e_dst[ch] = e_dst[ch] + (CH_DST_INC[ch] ? st : 32'h0);
    end
    chk("count", e_cnt[ch], WORK_COUNT[ch*32+:32]);
    chk("source", e_src[ch], SRC_PTR[ch*32+:32]);
    chk("dest", e_dst[ch], DST_PTR[ch*32+:32]);
  endtask
  initial begin
    repeat (20) @(negedge SYS_CLK);
    RST = 1'b0;
    @(negedge SYS_CLK);
    // byte units, source increments, destination fixed, pin trigger
    {CH_REPEAT, CH_SRC_INC, CH_PIN_TRIG} = 12'h111;
    cfg(0, 32'h5, 32'h400, 32'h1000);
    fire(0, 1'b1, 1'b0);
    CH_ENABLE = 4'h1;
    for (int i = 0; i < 7; i++) begin
      slow = i[0];
      unit(0, 1'b1);
    end
    // channels 1 to 3: byte, half and word units, both pointers moving
    {CH_REPEAT, CH_SRC_INC, CH_DST_INC, CH_PIN_TRIG} = 16'hfff0;
    CH_SIZE = 8'h90;
    for (int ch = 1; ch < 4; ch++) begin
      CH_ENABLE = 4'h1 << ch;
      cfg(ch, 32'h2, 32'h2000 * ch, 32'h3000 + 32'h100 * ch);
      repeat (3) unit(ch, 1'b0);
    end
    // single shot on channel 1: count runs out, channel stops, a later request moves nothing
    CH_REPEAT = 4'h0;
    CH_ENABLE = 4'h2;
    cfg(1, 32'h1, 32'h2400, 32'h3400);
    fire(1, 1'b0, 1'b1);
    chk("count", 32'h0, WORK_COUNT[63:32]);
    chk("stopped", 32'h2, 32'(CH_STOPPED));
    fire(1, 1'b0, 1'b0);
    chk("stopped", 32'h2, 32'(CH_STOPPED));
    close_out();
  end
endmodule // testbench
bind dma_repeat_engine dma_repeat_engine_sva #(.NCH(NCH)) u_dma_repeat_engine_sva (.SYS_CLK, .RST,
  .CFG_WRITE, .XFER_BUSY, .CH_ENABLE, .CH_REPEAT, .CH_DST_INC, .CH_PIN_TRIG, .EXT_REQ_N, .CH_SIZE,
  .WORK_COUNT, .SRC_PTR, .DST_PTR, .MEM_REQ, .MEM_WE, .MEM_GRANT, .MEM_ACK, .MEM_ADDR, .MEM_SIZE);
